/* uafc_ctrl.sv */
/*
 * Line-control logic of one UART channel: in-band pause/resume,
 * hardware handshake, automatic RS-485 driver enable with turnaround
 * delay, multidrop address matching and half-duplex receive blanking.
 * Assumes a UART core beside it that shifts characters, pulses
 * core_tx_done at the end of each stop bit and bit_tick once per bit
 * time at the programmed baud rate, and presents received characters
 * with the ninth or parity bit in bit 8.
 */
`timescale 1ns/1ps

module uafc_ctrl
    import uafc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] flow_ctrl,
    input wire logic [3:0] pin_func,
    input wire logic [3:0] turnaround_delay,
    input wire logic [7:0] resume_char,
    input wire logic [7:0] pause_char,
    input wire logic txf_valid,
    output logic txf_ready,
    input wire logic [8:0] txf_data,
    output logic core_tx_valid,
    input wire logic core_tx_ready,
    output logic [8:0] core_tx_data,
    input wire logic core_tx_busy,
    input wire logic core_tx_done,
    input wire logic bit_tick,
    input wire logic rx_pin,
    output logic rx_line,
    input wire logic core_rx_valid,
    output logic core_rx_ready,
    input wire logic [8:0] core_rx_data,
    output logic rxf_valid,
    input wire logic rxf_ready,
    output logic [8:0] rxf_data,
    input wire logic rxf_room,
    output logic driver_enable_pin,
    output logic tx_paused,
    output logic addr_matched
);

    // -------------------------------------------------------------
    // Mode decode
    // -------------------------------------------------------------
    logic [2:0] fc_mode;
    logic half_duplex;
    logic [2:0] pf_sel;
    logic sw_mode;
    logic hw_mode;
    logic md_mode;
    logic md_gated;
    logic rs485_mode;
    logic rts_mode;

    assign fc_mode = flow_ctrl[`UAFC_FC_MODE_MSB:0];
    assign half_duplex = flow_ctrl[`UAFC_FC_HALF_DUPLEX_BIT];
    assign pf_sel = pin_func[`UAFC_PF_SEL_MSB:0];
    assign sw_mode = (fc_mode == `UAFC_FC_SW);
    assign hw_mode = (fc_mode == `UAFC_FC_HW);
    assign md_mode = (fc_mode == `UAFC_FC_MD_RXONLY) | (fc_mode == `UAFC_FC_MD_GATED);
    assign md_gated = (fc_mode == `UAFC_FC_MD_GATED);
    assign rs485_mode = (pf_sel == `UAFC_PF_RS485);
    assign rts_mode = (pf_sel == `UAFC_PF_RTS) & hw_mode;

    // -------------------------------------------------------------
    // Receive pin synchroniser and blanking
    // -------------------------------------------------------------
    logic rx_sync1_reg;
    logic rx_sync2_reg;
    logic rx_line_reg;
    logic rx_blank;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_sync1_reg <= `UAFC_LINE_IDLE;
            rx_sync2_reg <= `UAFC_LINE_IDLE;
        end else begin
            rx_sync1_reg <= rx_pin;
            rx_sync2_reg <= rx_sync1_reg;
        end
    end

    // Own transmission must not echo into the receiver
    assign rx_blank = half_duplex & core_tx_busy;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_line_reg <= `UAFC_LINE_IDLE;
        end else begin
            rx_line_reg <= rx_blank ? `UAFC_LINE_IDLE : rx_sync2_reg;
        end
    end

    assign rx_line = rx_line_reg;

    // -------------------------------------------------------------
    // Received character classification
    // -------------------------------------------------------------
    logic rx_take;
    logic rx_is_addr;
    logic rx_hit_uni;
    logic rx_hit_multi;
    logic rx_hit_pause;
    logic rx_hit_resume;
    logic buf_in_ready;
    logic buf_in_valid;

    assign rx_take = core_rx_valid & core_rx_ready & ~rx_blank;
    assign rx_is_addr = core_rx_data[`UAFC_ADDR_BIT];
    assign rx_hit_uni = (core_rx_data[7:0] == resume_char);
    assign rx_hit_multi = (core_rx_data[7:0] == pause_char);
    assign rx_hit_pause = rx_take & sw_mode & (core_rx_data[7:0] == pause_char);
    assign rx_hit_resume = rx_take & sw_mode & (core_rx_data[7:0] == resume_char);

    // -------------------------------------------------------------
    // Pause state
    // -------------------------------------------------------------
    logic paused_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            paused_reg <= 1'h0;
        end else if (!sw_mode) begin
            paused_reg <= 1'h0;
        end else if (rx_hit_pause) begin
            paused_reg <= 1'h1;
        end else if (rx_hit_resume) begin
            paused_reg <= 1'h0;
        end
    end

    assign tx_paused = paused_reg;

    // -------------------------------------------------------------
    // Multidrop address match
    // -------------------------------------------------------------
    logic match_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            match_reg <= 1'h0;
        end else if (!md_mode) begin
            match_reg <= 1'h0;
        end else if (rx_take & rx_is_addr) begin
            if (rx_hit_uni | rx_hit_multi) begin
                match_reg <= 1'h1;
            end else begin
                match_reg <= 1'h0;
            end
        end
    end

    assign addr_matched = match_reg;

    // -------------------------------------------------------------
    // Receive path into the two-entry buffer
    // -------------------------------------------------------------
    assign core_rx_ready = buf_in_ready;
    assign buf_in_valid = core_rx_valid & ~rx_blank
        & (~md_mode | (match_reg & ~rx_is_addr));

    uafc_buf2 #(
        .WIDTH(`UAFC_CHAR_W)
    ) u_rx_buf (
        .clk(clk),
        .resetn(resetn),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(core_rx_data),
        .out_valid(rxf_valid),
        .out_ready(rxf_ready),
        .out_data(rxf_data)
    );

    // -------------------------------------------------------------
    // Transmit staging
    // -------------------------------------------------------------
    logic stage_valid_reg;
    logic [8:0] stage_data_reg;
    logic tx_allowed;
    logic tx_want;
    logic tx_hand;

    assign tx_allowed = ~paused_reg & (~md_gated | match_reg);
    assign tx_want = stage_valid_reg & tx_allowed;
    assign txf_ready = ~stage_valid_reg | tx_hand;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage_valid_reg <= 1'h0;
        end else if (txf_ready) begin
            stage_valid_reg <= txf_valid;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage_data_reg <= '0;
        end else if (txf_ready & txf_valid) begin
            stage_data_reg <= txf_data;
        end
    end

    assign core_tx_data = stage_data_reg;

    // -------------------------------------------------------------
    // Character in flight inside the shift core
    // -------------------------------------------------------------
    logic inflight_reg;

    // Tells a finished character from an offer that gating withdrew
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            inflight_reg <= 1'h0;
        end else if (tx_hand) begin
            inflight_reg <= 1'h1;
        end else if (core_tx_done) begin
            inflight_reg <= 1'h0;
        end
    end

    // -------------------------------------------------------------
    // Driver-enable sequencing
    // -------------------------------------------------------------
    uafc_de_e de_state_reg;
    uafc_de_e de_state_next;
    logic [`UAFC_DLY_W-1:0] hold_cnt_reg;
    logic de_live_reg;
    logic de_on;

    always_comb begin
        de_state_next = de_state_reg;
        case (de_state_reg)
            UAFC_DE_IDLE: begin
                if (rs485_mode & tx_want) begin
                    de_state_next = UAFC_DE_SEND;
                end
            end
            UAFC_DE_SEND: begin
                if (!rs485_mode) begin
                    de_state_next = UAFC_DE_IDLE;
                end else if (core_tx_done & ~tx_want & ~core_tx_valid) begin
                    if (turnaround_delay == 4'h0) begin
                        de_state_next = UAFC_DE_IDLE;
                    end else begin
                        de_state_next = UAFC_DE_HOLD;
                    end
                end else if (~tx_want & ~inflight_reg) begin
                    // Offer withdrawn before the core took it
                    if (turnaround_delay == 4'h0) begin
                        de_state_next = UAFC_DE_IDLE;
                    end else begin
                        de_state_next = UAFC_DE_HOLD;
                    end
                end
            end
            UAFC_DE_HOLD: begin
                if (!rs485_mode) begin
                    de_state_next = UAFC_DE_IDLE;
                end else if (tx_want) begin
                    de_state_next = UAFC_DE_SEND;
                end else if (bit_tick & (hold_cnt_reg == 4'h1)) begin
                    de_state_next = UAFC_DE_IDLE;
                end
            end
            default: begin
                de_state_next = UAFC_DE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            de_state_reg <= UAFC_DE_IDLE;
        end else begin
            de_state_reg <= de_state_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt_reg <= 4'h0;
        end else if (de_state_reg != UAFC_DE_HOLD) begin
            hold_cnt_reg <= turnaround_delay;
        end else if (bit_tick & (hold_cnt_reg != 4'h0)) begin
            hold_cnt_reg <= hold_cnt_reg - 4'h1;
        end
    end

    assign de_on = (de_state_next != UAFC_DE_IDLE);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            de_live_reg <= 1'h0;
        end else begin
            de_live_reg <= de_on;
        end
    end

    // Character goes to the core only once the pin already drives
    assign core_tx_valid = tx_want
        & (~rs485_mode | (de_live_reg & (de_state_reg == UAFC_DE_SEND)));
    assign tx_hand = core_tx_valid & core_tx_ready;

    // -------------------------------------------------------------
    // Shared enable / request-to-send pin
    // -------------------------------------------------------------
    logic pin_reg;

    // Inactive level until a pin use is chosen
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_reg <= `UAFC_PIN_RST;
        end else if (rs485_mode) begin
            pin_reg <= de_on ^ pin_func[`UAFC_PF_POL_BIT];
        end else if (rts_mode) begin
            pin_reg <= ~rxf_room;
        end else begin
            pin_reg <= `UAFC_PIN_RST;
        end
    end

    assign driver_enable_pin = pin_reg;

endmodule

/* uafc_defs.svh */
/*
 * Constants for the UART line-control block: field codes, field
 * positions and reset values.
 * Assumes it is included by bare name from the package.
 */
`ifndef UAFC_DEFS_SVH
`define UAFC_DEFS_SVH

// -----------------------------------------------------------------
// Flow control field
// -----------------------------------------------------------------
`define UAFC_FC_MODE_MSB 2
`define UAFC_FC_HALF_DUPLEX_BIT 3
`define UAFC_FC_HW 3'h1
`define UAFC_FC_SW 3'h2
`define UAFC_FC_MD_RXONLY 3'h3
`define UAFC_FC_MD_GATED 3'h4

// -----------------------------------------------------------------
// Pin function field
// -----------------------------------------------------------------
`define UAFC_PF_SEL_MSB 2
`define UAFC_PF_POL_BIT 3
`define UAFC_PF_RTS 3'h1
`define UAFC_PF_RS485 3'h3

// -----------------------------------------------------------------
// Widths and reset values
// -----------------------------------------------------------------
`define UAFC_CHAR_W 9
`define UAFC_ADDR_BIT 8
`define UAFC_DLY_W 4
`define UAFC_PIN_RST 1'h1
`define UAFC_LINE_IDLE 1'h1

`endif

/* uafc_pkg.sv */
/*
 * Types for the UART line-control block.
 * Assumes uafc_defs.svh is on the include path.
 */
`include "uafc_defs.svh"

package uafc_pkg;

    // -------------------------------------------------------------
    // Driver-enable sequencing states
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        UAFC_DE_IDLE,
        UAFC_DE_SEND,
        UAFC_DE_HOLD
    } uafc_de_e;

    typedef logic [`UAFC_CHAR_W-1:0] uafc_char_t;

endpackage

/* uafc_buf2.sv */
/*
 * Two-entry skid buffer with valid and ready on both sides.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps

module uafc_buf2 #(
    parameter int WIDTH = 9
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    // -------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------
    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] tail_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = head_reg;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 2'h0;
        end else if (push & ~pop) begin
            count_reg <= count_reg + 2'h1;
        end else if (pop & ~push) begin
            count_reg <= count_reg - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            head_reg <= '0;
            tail_reg <= '0;
        end else begin
            if (pop) begin
                head_reg <= (count_reg == 2'h2) ? tail_reg : in_data;
            end else if (push & (count_reg == 2'h0)) begin
                head_reg <= in_data;
            end
            if (push & ((count_reg == 2'h2) | ((count_reg == 2'h1) & ~pop))) begin
                tail_reg <= in_data;
            end
        end
    end

endmodule

/* uafc_ctrl_chk.sv */
/* Assertions on the ports of uafc_ctrl.
   Assumes one clock clk and reset resetn; bound to every uafc_ctrl. */
`timescale 1ns/1ps
module uafc_ctrl_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] flow_ctrl,
    input wire logic [3:0] pin_func,
    input wire logic [3:0] turnaround_delay,
    input wire logic [7:0] resume_char,
    input wire logic [7:0] pause_char,
    input wire logic txf_valid,
    input wire logic core_tx_valid,
    input wire logic core_tx_busy,
    input wire logic core_tx_done,
    input wire logic rx_line,
    input wire logic core_rx_valid,
    input wire logic core_rx_ready,
    input wire logic [8:0] core_rx_data,
    input wire logic rxf_room,
    input wire logic driver_enable_pin,
    input wire logic tx_paused,
    input wire logic addr_matched
);
    // ----------------
    // Properties
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rs = pin_func[2:0] == 3'h3;
    wire [2:0] md = flow_ctrl[2:0];
    wire rts = md == 3'h1 && pin_func[2:0] == 3'h1;
    wire adr = (md == 3'h3 || md == 3'h4) && core_rx_valid && core_rx_ready
        && core_rx_data[8] && !(flow_ctrl[3] && core_tx_busy);
    wire hit = core_rx_data[7:0] == resume_char || core_rx_data[7:0] == pause_char;
    wire gt = md == 3'h4 && !addr_matched;
    a_de_on: assert property (rs && core_tx_busy && $stable(pin_func)
        |-> driver_enable_pin != pin_func[3]) else $error("enable off while shifting");
    a_de_zero: assert property (rs && turnaround_delay == 4'h0 && core_tx_done
        && !core_tx_valid && !txf_valid |-> ##[1:2] driver_enable_pin == pin_func[3])
        else $error("enable not released");
    a_de_hold: assert property (rs && turnaround_delay != 4'h0 && core_tx_done
        |=> driver_enable_pin != pin_func[3]) else $error("enable released early");
    a_rx_blank: assert property ((flow_ctrl[3] && core_tx_busy) [*2] |-> rx_line)
        else $error("receive not blanked");
    a_sw_only: assert property (md != 3'h2 && $past(md) != 3'h2 |-> !tx_paused)
        else $error("paused outside mode");
    a_addr_hit: assert property (adr && hit |=> addr_matched)
        else $error("address not matched");
    a_addr_miss: assert property (adr && !hit |=> !addr_matched)
        else $error("match kept on miss");
    a_gate_tx: assert property (gt && $past(gt) |-> !core_tx_valid)
        else $error("send while unmatched");
    a_rts_room: assert property (rts && $past(rts)
        |-> driver_enable_pin == !$past(rxf_room)) else $error("request to send wrong");
    c_pause: cover property ($fell(tx_paused));
    c_match: cover property ($rose(addr_matched));
    c_hold: cover property (rs && core_tx_done && turnaround_delay == 4'hF);
endmodule

bind uafc_ctrl uafc_ctrl_chk uafc_ctrl_chk_inst (.*);

/* uafc_core_model.sv */
/* Model of the UART shift core beside uafc_ctrl.
   Assumes clk and resetn of the block; one bit time is four clocks. */
`timescale 1ns/1ps
module uafc_core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic core_tx_valid,
    output logic core_tx_ready,
    output logic core_tx_busy,
    output logic core_tx_done,
    output logic bit_tick
);
    // ----------------
    // Shifter
    // ----------------
    logic [1:0] div_reg;
    logic [3:0] bit_reg;
    assign bit_tick = div_reg == 2'h3;
    // Slow answer accepts only on odd divider phases
    assign core_tx_ready = !core_tx_busy && !(slow && !div_reg[0]);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= 2'h0;
            bit_reg <= 4'h0;
            core_tx_busy <= 1'h0;
            core_tx_done <= 1'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
            core_tx_done <= 1'h0;
            if (core_tx_valid && core_tx_ready) begin
                core_tx_busy <= 1'h1;
                bit_reg <= 4'hA;
            end else if (core_tx_busy && bit_tick) begin
                bit_reg <= bit_reg - 4'h1;
                if (bit_reg == 4'h0) begin
                    core_tx_busy <= 1'h0;
                    core_tx_done <= 1'h1;
                end
            end
        end
    end
endmodule

/* uafc_ctrl_bench.sv */
/* Self-checking bench for uafc_ctrl with a shift core model.
   Assumes package, design, model and checker are compiled first. */
`timescale 1ns/1ps
module uafc_ctrl_bench
    import uafc_pkg::*;
;
    logic clk = 1'h0, resetn = 1'h0, txf_valid = 1'h0, rx_pin = 1'h1, core_rx_valid = 1'h0;
    logic rxf_ready = 1'h1, rxf_room = 1'h1, slow = 1'h0, stall = 1'h0;
    logic [3:0] flow_ctrl = 4'h0, pin_func = 4'h0, turnaround_delay = 4'h0;
    logic [7:0] resume_char = 8'h11, pause_char = 8'h13;
    uafc_char_t txf_data = 9'h000, core_rx_data = 9'h000, core_tx_data, rxf_data;
    logic txf_ready, core_tx_valid, core_tx_ready, core_tx_busy, core_tx_done, bit_tick;
    logic rx_line, core_rx_ready, rxf_valid, driver_enable_pin, tx_paused, addr_matched;
    uafc_char_t rxq[$], txq[$];
    logic [31:0] seed = 32'h50;
    int bad_count = 0, tests_run = 0, c, k;
    int dly[4] = '{0, 1, 5, 15};
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input string nm, input uafc_char_t seen, input uafc_char_t exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic rx(input uafc_char_t d, input logic keep);
        int i;
        @(negedge clk);
        core_rx_valid = 1'h1;
        core_rx_data = d;
        if (keep) rxq.push_back(d);
        for (i = 0; i < 300 && !core_rx_ready; i++) @(negedge clk);
        @(negedge clk);
        core_rx_valid = 1'h0;
    endtask
    task automatic tx(input uafc_char_t d);
        int i;
        @(negedge clk);
        txf_valid = 1'h1;
        txf_data = d;
        txq.push_back(d);
        #1;
        for (i = 0; i < 300 && !txf_ready; i++) begin
            @(negedge clk);
            #1;
        end
        @(negedge clk);
        txf_valid = 1'h0;
    endtask
    uafc_ctrl uafc_ctrl_inst (.*);
    uafc_core_model uafc_core_model_inst (.*);
    initial begin
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        seed = xs(seed);
        rxf_room <= seed[3];
        slow <= seed[5];
        rxf_ready <= !stall && seed[7:6] != 2'h0;
    end
    always @(posedge clk) begin
        if (rxf_valid && rxf_ready) begin
            chk("rx", rxf_data, rxq.size() ? rxq.pop_front() : ~rxf_data);
        end
        if (core_tx_valid && core_tx_ready) begin
            chk("tx", core_tx_data, txq.size() ? txq.pop_front() : ~core_tx_data);
        end
    end
    initial begin
        #400000;
        bad_count++;
        tally_and_finish();
    end
    // ----------------
    // Scenarios
    // ----------------
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        resetn = 1'h1;
        for (k = 0; k < 8; k++) begin
            seed = xs(seed);
            rx(seed[24:16], 1'h1);
            tx(seed[8:0]);
        end
        while (rxq.size() != 0) @(negedge clk);
        stall = 1'h1;
        rx(9'h0A5, 1'h1);
        rx(9'h15A, 1'h1);
        chk("rx full", 9'(core_rx_ready), 9'h000);
        stall = 1'h0;
        $display("plain done");
        flow_ctrl = 4'h1;
        pin_func = 4'h1;
        rx({1'h0, pause_char}, 1'h1);
        repeat (20) @(negedge clk);
        chk("pause mode 1", 9'(tx_paused), 9'h000);
        flow_ctrl = 4'h2;
        pin_func = 4'h0;
        while (txq.size() != 0 || core_tx_busy) @(negedge clk);
        tx(9'h0C3);
        while (!core_tx_busy) @(negedge clk);
        rx({1'h0, pause_char}, 1'h1);
        tx(9'h03C);
        chk("pause", 9'(tx_paused), 9'h001);
        repeat (60) @(negedge clk);
        chk("held", 9'(txq.size()), 9'h001);
        rx({1'h0, resume_char}, 1'h1);
        repeat (60) @(negedge clk);
        chk("resumed", 9'(txq.size()), 9'h000);
        $display("pause done");
        while (txq.size() != 0 || core_tx_busy) @(negedge clk);
        flow_ctrl = 4'h8;
        for (k = 0; k < 8; k++) begin
            pin_func = {k[0], 3'h3};
            turnaround_delay = 4'(dly[k / 2]);
            repeat (80) @(negedge clk);
            chk("enable idle", 9'(driver_enable_pin), 9'(k[0]));
            seed = xs(seed);
            tx(seed[8:0]);
            while (!core_tx_busy) @(negedge clk);
            rx_pin = 1'h0;
            rx(9'h055, 1'h0);
            while (!core_tx_done) @(negedge clk);
            for (c = 0; driver_enable_pin !== k[0] && c < 100; c++) @(negedge clk);
            chk("hold", 9'(c >= (k < 2 ? 1 : 4 * dly[k / 2] - 3) && c <= 4 * dly[k / 2] + 2),
                9'h001);
            chk("rx line", 9'(rx_line), 9'h000);
            rx_pin = 1'h1;
        end
        $display("enable done");
        pin_func = 4'h0;
        resume_char = 8'h21;
        pause_char = 8'h42;
        for (k = 3; k < 5; k++) begin
            flow_ctrl = 4'(k);
            rx(9'h133, 1'h0);
            rx(9'h0AA, 1'h0);
            chk("miss", 9'(addr_matched), 9'h000);
            tx(9'h066);
            repeat (60) @(negedge clk);
            chk("tx gate", 9'(txq.size()), 9'(k == 4));
            rx({1'h1, k == 3 ? resume_char : pause_char}, 1'h0);
            rx(9'h0B0, 1'h1);
            chk("hit", 9'(addr_matched), 9'h001);
            repeat (60) @(negedge clk);
            chk("tx sent", 9'(txq.size()), 9'h000);
            rx(9'h1FF, 1'h0);
            rx(9'h0CC, 1'h0);
        end
        repeat (100) @(negedge clk);
        chk("rx left", 9'(rxq.size()), 9'h000);
        $display("multidrop done");
        tally_and_finish();
    end
endmodule
